// ---- vm_pkg.sv ----
// constants, register map and mode codes for the sensor video memory processing block
// Behaviour
// [R1] accept framing TV of 525, 625, 875 or 1075 lines and store it digitized
// [R2] discard imagery outside the 1024x1024 area; keep the centre of a reduced frame
// [R3] map 5-bit TV samples through the loadable level-slice table to 4 bits
// [R4] level-slice table holds a linear mapping from reset until reloaded
// [R5] serial video up to 10 MHz loads memory directly; sender keeps under that rate
// [R6] display magnification of two or four, chosen by the display processor
// [R7] separate magnification start and end addresses for video and graphics
// [R8] magnified pixels falling beyond the area boundary are not output
// [R9] video scrolls in Y on its own, top line given in steps of two lines
// [R10] freeze stops new samples being written, contents stay displayed
// [R11] integration: old plus difference divided by 2^K, K is 1 or 2
// [R12] trails: take new sample if not below old, else integrate toward it
// [R13] peak detect: take new sample if not below old, else keep old
// [R14] continuous erase clears each pixel after it was read out once; an erase that meets a sensor write is dropped
// [R15] video memory is 1024x1024 pixels of 4-bit intensity
// [R16] one combine mode at a time; none selected means plain overwrite
// [R17] divide by arithmetic right shift of signed difference, clamp to 4 bits
package vm_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned VA_AW  = 10;
  localparam int unsigned PIX_W  = 4;
  localparam int unsigned TV_W   = 5;
  localparam logic [10:0] VA_SIZE = 11'h400;
  localparam logic [10:0] LINES_525  = 11'h20d;
  localparam logic [10:0] LINES_625  = 11'h271;
  localparam logic [10:0] LINES_875  = 11'h36b;
  localparam logic [10:0] LINES_1075 = 11'h433;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SER_MAX_MHZ = 10;
  localparam logic [3:0]  SER_GAP_CYC = 4'((CLK_MHZ + SER_MAX_MHZ - 1) / SER_MAX_MHZ);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFF   = 12'h000;
  localparam logic [11:0] SCROLL_OFF = 12'h004;
  localparam logic [11:0] VSTART_OFF = 12'h008;
  localparam logic [11:0] VEND_OFF   = 12'h00c;
  localparam logic [11:0] GSTART_OFF = 12'h010;
  localparam logic [11:0] GEND_OFF   = 12'h014;
  localparam logic [11:0] LUT_OFF    = 12'h018;
  localparam logic [11:0] STATUS_OFF = 12'h01c;

  localparam int unsigned CTRL_W       = 9;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_K_BIT   = 2;
  localparam int unsigned CTRL_FRZ_BIT = 3;
  localparam int unsigned CTRL_ERS_BIT = 4;
  localparam int unsigned CTRL_MAG_LSB = 5;
  localparam int unsigned CTRL_FMT_LSB = 7;
  localparam int unsigned Y_LSB        = 16;
  localparam int unsigned LUT_IDX_LSB  = 16;

  localparam logic [8:0]  CTRL_RST   = 9'h000;
  localparam logic [8:0]  SCROLL_RST = 9'h000;
  localparam logic [31:0] START_RST  = 32'h0000_0000;
  localparam logic [31:0] VEND_RST   = 32'h03ff_03ff;
  localparam logic [31:0] GEND_RST   = 32'h05ff_05ff;

  typedef enum logic [1:0] {
    MODE_REPLACE = 2'h0,
    MODE_INTEG   = 2'h1,
    MODE_TRAIL   = 2'h2,
    MODE_PEAK    = 2'h3
  } mode_t;

endpackage

// ---- level_slice_lut.sv ----
// level-slice lookup table from digitized TV samples to stored intensity
`timescale 1ns/1ps
module level_slice_lut
  import vm_pkg::*;
#(
  parameter int unsigned IN_W  = TV_W,
  parameter int unsigned OUT_W = PIX_W
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_en,
  input  wire logic [IN_W-1:0]  wr_idx,
  input  wire logic [OUT_W-1:0] wr_val,
  input  wire logic [IN_W-1:0]  tv_idx,
  output logic      [OUT_W-1:0] tv_val,
  input  wire logic [IN_W-1:0]  cpu_idx,
  output logic      [OUT_W-1:0] cpu_val
);

  logic [OUT_W-1:0] lut_q [2**IN_W];
  logic [OUT_W-1:0] lut_d [2**IN_W];

  always_comb
  begin
    lut_d = lut_q;
    if (wr_en)
    begin
      lut_d[wr_idx] = wr_val;
    end
  end

  // [R4] linear after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 2**IN_W; i++)
      begin
        lut_q[i] <= OUT_W'(i >> (IN_W - OUT_W));
      end
    end
    else
    begin
      lut_q <= lut_d;
    end
  end

  // [R3] slice five bits to four
  assign tv_val  = lut_q[tv_idx];
  assign cpu_val = lut_q[cpu_idx];

endmodule

// ---- pixel_combiner.sv ----
// scan-to-scan combine of a new sample with the stored pixel
`timescale 1ns/1ps
module pixel_combiner
  import vm_pkg::*;
#(
  parameter int unsigned W = PIX_W
)(
  input  wire mode_t        mode,
  input  wire logic         k2,
  input  wire logic [W-1:0] old_pix,
  input  wire logic [W-1:0] new_pix,
  output logic      [W-1:0] res
);

  logic signed [W+1:0] diff;
  logic signed [W+1:0] step;
  logic signed [W+1:0] sum;
  logic        [W-1:0] integ;

  always_comb
  begin
    diff = $signed({2'b00, new_pix}) - $signed({2'b00, old_pix});
    // [R17] arithmetic shift, then clamp
    step = k2 ? (diff >>> 2) : (diff >>> 1);
    sum  = $signed({2'b00, old_pix}) + step;
    if (sum < 0)
      integ = '0;
    else if (sum > $signed({2'b00, {W{1'b1}}}))
      integ = '1;
    else
      integ = sum[W-1:0];
    // [R16] one mode, else overwrite
    unique case (mode)
      // [R11] integration update
      MODE_INTEG: res = integ;
      // [R12] trails follow peaks
      MODE_TRAIL: res = (new_pix >= old_pix) ? new_pix : integ;
      // [R13] peak hold
      MODE_PEAK:  res = (new_pix >= old_pix) ? new_pix : old_pix;
      default:    res = new_pix;
    endcase
  end

endmodule

// ---- sensor_video_memory_processing.sv ----
// sensor video memory: write-path combine, read-out magnify/scroll/erase, APB registers
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module sensor_video_memory_processing
  import vm_pkg::*;
#(
  parameter logic [10:0] TV_WIDTH = VA_SIZE
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        tv_valid,
  input  wire logic [4:0]  tv_sample,
  input  wire logic [10:0] tv_x,
  input  wire logic [10:0] tv_y,
  input  wire logic        ser_valid,
  input  wire logic [3:0]  ser_data,
  input  wire logic [19:0] ser_addr,
  input  wire logic        disp_req,
  input  wire logic [9:0]  disp_x,
  input  wire logic [9:0]  disp_y,
  output logic             vid_valid,
  output logic      [3:0]  vid_pix,
  output logic             vid_blank,
  input  wire logic        gfx_req,
  input  wire logic [10:0] gfx_x,
  input  wire logic [10:0] gfx_y,
  output logic             gfx_valid,
  output logic      [10:0] gfx_mx,
  output logic      [10:0] gfx_my,
  output logic             gfx_blank
);

  localparam logic [10:0] TV_XOFF = (TV_WIDTH > VA_SIZE) ? 11'((TV_WIDTH - VA_SIZE) >> 1) : 11'h000;

  // [R15] 1024 x 1024 x 4-bit store
  logic [PIX_W-1:0] mem [2**(2*VA_AW)];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [8:0]  ctrl_q, ctrl_d, scroll_q, scroll_d;
  logic [31:0] vs_q, vs_d, ve_q, ve_d, gs_q, gs_d, ge_q, ge_d;
  logic [4:0]  lut_idx_q, lut_idx_d;
  logic [31:0] prdata_q, prdata_d;
  logic        rate_q, rate_d;
  logic        apb_wr, apb_rd, mapped, lut_we;
  logic [3:0]  lut_tv, lut_cpu;
  mode_t       mode;
  logic        k2, frz, ers;
  logic [1:0]  mag, fmt;

  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;
  assign mapped  = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;
  assign lut_we  = apb_wr && (paddr == LUT_OFF);

  assign mode = mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign k2   = ctrl_q[CTRL_K_BIT];
  assign frz  = ctrl_q[CTRL_FRZ_BIT];
  assign ers  = ctrl_q[CTRL_ERS_BIT];
  assign mag  = ctrl_q[CTRL_MAG_LSB +: 2];
  assign fmt  = ctrl_q[CTRL_FMT_LSB +: 2];

  logic       rate_viol;
  logic [3:0] gap_q, gap_d;

  always_comb
  begin
    ctrl_d    = ctrl_q;
    scroll_d  = scroll_q;
    vs_d      = vs_q;
    ve_d      = ve_q;
    gs_d      = gs_q;
    ge_d      = ge_q;
    lut_idx_d = lut_idx_q;
    prdata_d  = prdata_q;
    // status flag: a new violation beats a same-cycle clear
    rate_d    = rate_q;
    if (apb_wr && paddr == STATUS_OFF && pwdata[0])
      rate_d = 1'b0;
    if (rate_viol)
      rate_d = 1'b1;
    if (apb_wr)
    begin
      unique case (paddr)
        CTRL_OFF:   ctrl_d    = pwdata[CTRL_W-1:0];
        SCROLL_OFF: scroll_d  = pwdata[8:0];
        VSTART_OFF: vs_d      = pwdata & 32'h03ff_03ff;
        VEND_OFF:   ve_d      = pwdata & 32'h03ff_03ff;
        GSTART_OFF: gs_d      = pwdata & 32'h07ff_07ff;
        GEND_OFF:   ge_d      = pwdata & 32'h07ff_07ff;
        LUT_OFF:    lut_idx_d = pwdata[LUT_IDX_LSB +: 5];
        default:    ;
      endcase
    end
    if (apb_rd)
    begin
      unique case (paddr)
        CTRL_OFF:   prdata_d = {23'h0, ctrl_q};
        SCROLL_OFF: prdata_d = {23'h0, scroll_q};
        VSTART_OFF: prdata_d = vs_q;
        VEND_OFF:   prdata_d = ve_q;
        GSTART_OFF: prdata_d = gs_q;
        GEND_OFF:   prdata_d = ge_q;
        LUT_OFF:    prdata_d = {11'h0, lut_idx_q, 12'h0, lut_cpu};
        STATUS_OFF: prdata_d = {30'h0, frz, rate_q};
        default:    prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q    <= CTRL_RST;
      scroll_q  <= SCROLL_RST;
      vs_q      <= START_RST;
      ve_q      <= VEND_RST;
      gs_q      <= START_RST;
      ge_q      <= GEND_RST;
      lut_idx_q <= 5'h00;
      prdata_q  <= 32'h0000_0000;
      rate_q    <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      scroll_q  <= scroll_d;
      vs_q      <= vs_d;
      ve_q      <= ve_d;
      gs_q      <= gs_d;
      ge_q      <= ge_d;
      lut_idx_q <= lut_idx_d;
      prdata_q  <= prdata_d;
      rate_q    <= rate_d;
    end
  end

  level_slice_lut u_lut (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (lut_we),
    .wr_idx  (pwdata[LUT_IDX_LSB +: 5]),
    .wr_val  (pwdata[3:0]),
    .tv_idx  (tv_sample),
    .tv_val  (lut_tv),
    .cpu_idx (lut_idx_q),
    .cpu_val (lut_cpu)
  );

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  logic [10:0] lines, yoff;
  logic [11:0] ry, rx;
  logic        tv_in, acc;
  logic [19:0] acc_addr, wa_q, wa_d, ea_q, ea_d;
  logic [3:0]  acc_pix, wx_q, wx_d, old_q, old_d, cmb;
  logic        wv_q, wv_d, ev_q, ev_d, mem_we;
  logic [3:0]  mem_wdata;
  logic [19:0] mem_waddr;

  always_comb
  begin
    // [R1] frame format select
    unique case (fmt)
      2'h0:    lines = LINES_525;
      2'h1:    lines = LINES_625;
      2'h2:    lines = LINES_875;
      default: lines = LINES_1075;
    endcase
    // [R2] centre crop, no rescale
    yoff  = (lines > VA_SIZE) ? 11'((lines - VA_SIZE) >> 1) : 11'h000;
    ry    = {1'b0, tv_y} - {1'b0, yoff};
    rx    = {1'b0, tv_x} - {1'b0, TV_XOFF};
    tv_in = tv_valid && (tv_y < lines) && (tv_x < TV_WIDTH) && !ry[11] && !rx[11]
            && (ry[10:0] < VA_SIZE) && (rx[10:0] < VA_SIZE);
    // [R5] serial loads directly; it takes the slot if both arrive
    acc_addr = ser_valid ? ser_addr : {ry[9:0], rx[9:0]};
    acc_pix  = ser_valid ? ser_data : lut_tv;
    // [R10] frozen memory takes no samples
    acc      = !frz && (ser_valid || tv_in);
    wv_d     = acc;
    wa_d     = acc ? acc_addr : wa_q;
    wx_d     = acc ? acc_pix : wx_q;
    // forward the write in flight so back-to-back hits see fresh data
    old_d    = (wv_q && wa_q == acc_addr) ? cmb : mem[acc_addr];
    // rate check: fewer than SER_GAP_CYC cycles between serial samples
    rate_viol = ser_valid && (gap_q < SER_GAP_CYC - 4'h1);
    gap_d     = ser_valid ? 4'h0 : ((gap_q == 4'hf) ? gap_q : gap_q + 4'h1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wv_q  <= 1'b0;
      wa_q  <= 20'h00000;
      wx_q  <= 4'h0;
      old_q <= 4'h0;
      gap_q <= 4'hf;
    end
    else
    begin
      wv_q  <= wv_d;
      wa_q  <= wa_d;
      wx_q  <= wx_d;
      old_q <= old_d;
      gap_q <= gap_d;
    end
  end

  pixel_combiner u_cmb (
    .mode    (mode),
    .k2      (k2),
    .old_pix (old_q),
    .new_pix (wx_q),
    .res     (cmb)
  );

  // sensor write beats a pending erase; that erase is dropped and the read-out pixel at ea_q is not cleared
  always_comb
  begin
    mem_we    = 1'b0;
    mem_waddr = wa_q;
    mem_wdata = cmb;
    if (wv_q && !frz)
      mem_we = 1'b1;
    else if (ev_q && !frz)
    begin
      // [R14] clear after one read-out
      mem_we    = 1'b1;
      mem_waddr = ea_q;
      mem_wdata = 4'h0;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;
  end

  // ----------------------------------------------------------------
  // read-out path
  // ----------------------------------------------------------------
  logic [1:0]  sh;
  logic [10:0] mx, my, gmx, gmy;
  logic [9:0]  row;
  logic        vblank, gin, gblk;
  logic        vv_q, vv_d, vb_q, vb_d, gv_q, gv_d, gb_q, gb_d;
  logic [3:0]  vp_q, vp_d;
  logic [10:0] gx_q, gx_d, gy_q, gy_d;

  always_comb
  begin
    // [R6] two or four times
    sh = (mag == 2'h1) ? 2'h1 : ((mag == 2'h2) ? 2'h2 : 2'h0);
    // [R7] video window
    mx = {1'b0, vs_q[9:0]} + 11'({1'b0, disp_x} >> sh);
    my = {1'b0, vs_q[Y_LSB +: 10]} + 11'({1'b0, disp_y} >> sh);
    // [R8] beyond the end address is blanked
    vblank = (mx > {1'b0, ve_q[9:0]}) || (my > {1'b0, ve_q[Y_LSB +: 10]}) || mx[10] || my[10];
    // [R9] scroll in two-line steps
    row  = my[9:0] + {scroll_q, 1'b0};
    vv_d = disp_req;
    vb_d = disp_req ? vblank : vb_q;
    vp_d = disp_req ? (vblank ? 4'h0 : mem[{row, mx[9:0]}]) : vp_q;
    ev_d = disp_req && ers && !vblank && !frz;
    ea_d = disp_req ? {row, mx[9:0]} : ea_q;
    // [R7] graphics window, outside passes unmagnified
    gin  = (gfx_x >= gs_q[10:0]) && (gfx_x <= ge_q[10:0])
           && (gfx_y >= gs_q[Y_LSB +: 11]) && (gfx_y <= ge_q[Y_LSB +: 11]);
    gmx  = gin ? gs_q[10:0] + ((gfx_x - gs_q[10:0]) >> sh) : gfx_x;
    gmy  = gin ? gs_q[Y_LSB +: 11] + ((gfx_y - gs_q[Y_LSB +: 11]) >> sh) : gfx_y;
    // [R8] magnified graphics past the window end
    gblk = gin && ((gmx > ge_q[10:0]) || (gmy > ge_q[Y_LSB +: 11]));
    gv_d = gfx_req;
    gb_d = gfx_req ? gblk : gb_q;
    gx_d = gfx_req ? gmx : gx_q;
    gy_d = gfx_req ? gmy : gy_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vv_q <= 1'b0;
      vb_q <= 1'b0;
      vp_q <= 4'h0;
      ev_q <= 1'b0;
      ea_q <= 20'h00000;
      gv_q <= 1'b0;
      gb_q <= 1'b0;
      gx_q <= 11'h000;
      gy_q <= 11'h000;
    end
    else
    begin
      vv_q <= vv_d;
      vb_q <= vb_d;
      vp_q <= vp_d;
      ev_q <= ev_d;
      ea_q <= ea_d;
      gv_q <= gv_d;
      gb_q <= gb_d;
      gx_q <= gx_d;
      gy_q <= gy_d;
    end
  end

  assign vid_valid = vv_q;
  assign vid_blank = vb_q;
  assign vid_pix   = vp_q;
  assign gfx_valid = gv_q;
  assign gfx_blank = gb_q;
  assign gfx_mx    = gx_q;
  assign gfx_my    = gy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_freeze_hold: // [R10]
    assert property (frz |-> !mem_we) else $error("video memory written while frozen");
  a_replace_direct: // [R16]
    assert property (wv_q && !frz && mode == MODE_REPLACE |-> mem_wdata == wx_q)
      else $error("overwrite mode altered the sample");
  a_peak_keep: // [R13]
    assert property (wv_q && !frz && mode == MODE_PEAK && wx_q < old_q |-> mem_wdata == old_q)
      else $error("peak detect lost the stored peak");
  a_trail_take: // [R12]
    assert property (wv_q && !frz && mode == MODE_TRAIL && wx_q >= old_q |-> mem_wdata == wx_q)
      else $error("trails did not take the larger sample");
  a_integ_half: // [R11]
    assert property (wv_q && !frz && mode == MODE_INTEG && !k2 && wx_q == 4'ha && old_q == 4'h4
                     |-> mem_wdata == 4'h7) else $error("integration with K=1 wrong");
  a_integ_quarter: // [R17]
    assert property (wv_q && !frz && mode == MODE_INTEG && k2 && wx_q == 4'h0 && old_q == 4'hf
                     |-> mem_wdata == 4'hb) else $error("integration with K=2 wrong");
  a_frame_crop: // [R2]
    assert property (tv_valid && !ser_valid && tv_y < yoff |=> !wv_q)
      else $error("line outside the video area was stored");
  a_erase_zero: // [R14]
    assert property (disp_req && ers && !frz && !vblank ##1 !(wv_q && !frz) && !frz
                     |-> mem_we && mem_wdata == 4'h0 && mem_waddr == $past(ea_d))
      else $error("read-out pixel not erased");
  a_mag_blank: // [R8]
    assert property (disp_req && mx > {1'b0, ve_q[9:0]} |=> vid_valid && vid_blank && vid_pix == 4'h0)
      else $error("pixel beyond video area shown");
  a_rate_flag: // [R5]
    assert property (ser_valid ##[1:9] ser_valid |=> rate_q) else $error("serial overrun not flagged");

  c_trails:   cover property (wv_q && mode == MODE_TRAIL && wx_q < old_q);
  c_erase:    cover property (ev_q && mem_we);
  c_mag_four: cover property (disp_req && mag == 2'h2 ##1 vid_blank);
  c_freeze:   cover property ($rose(frz) ##1 tv_valid);

endmodule

// ---- ser_source.sv ----
// paced serial line-scan video source feeding the sensor memory block
`timescale 1ns/1ps
module ser_source
  import vm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic        rush,
  input  wire logic [3:0]  pix,
  input  wire logic [19:0] addr,
  output logic             busy,
  output logic             ser_valid,
  output logic      [3:0]  ser_data,
  output logic      [19:0] ser_addr
);
  logic [3:0]  gap_q, gap_d;
  logic        pend_q, pend_d;
  logic        vld_q, vld_d;
  logic [23:0] word_q, word_d;

  // sample pacing
  // one sample per gap; rush exists only to break the rate on purpose
  always_comb
  begin
    gap_d  = (gap_q != 4'h0) ? gap_q - 4'h1 : gap_q;
    pend_d = pend_q | go;
    word_d = go ? {pix, addr} : word_q;
    vld_d  = 1'b0;
    if (pend_q && (gap_q == 4'h0 || rush))
    begin
      vld_d  = 1'b1;
      pend_d = go;
      gap_d  = SER_GAP_CYC;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q  <= 4'h0;
      pend_q <= 1'b0;
      vld_q  <= 1'b0;
      word_q <= 24'h0;
    end
    else
    begin
      gap_q  <= gap_d;
      pend_q <= pend_d;
      vld_q  <= vld_d;
      word_q <= word_d;
    end
  end

  // idle lines carry the inverse so a stale value never looks like data
  assign ser_valid            = vld_q;
  assign {ser_data, ser_addr} = vld_q ? word_q : ~word_q;
  assign busy                 = pend_q | vld_q;
endmodule

// ---- tb.sv ----
// self-checking bench for the sensor video memory processing block
`timescale 1ns/1ps
module tb import vm_pkg::*;;
  typedef struct packed {logic [1:0] mode; logic k2; logic [3:0] old; logic [3:0] nw; logic [3:0] exp;} row_t;
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic        tv_valid  = 1'b0;
  logic [4:0]  tv_sample = 5'h00;
  logic [10:0] tv_x      = 11'h000;
  logic [10:0] tv_y      = 11'h000;
  logic        disp_req  = 1'b0;
  logic [9:0]  disp_x    = 10'h000;
  logic [9:0]  disp_y    = 10'h000;
  logic        gfx_req   = 1'b0;
  logic [10:0] gfx_x     = 11'h000;
  logic [10:0] gfx_y     = 11'h000;
  logic        s_go      = 1'b0;
  logic        s_rush    = 1'b0;
  logic [3:0]  s_pix     = 4'h0;
  logic [19:0] s_addr    = 20'h0;
  logic        pready, pslverr, vid_valid, vid_blank, gfx_valid, gfx_blank, ser_valid, s_busy, err;
  logic [31:0] prdata, rd;
  logic [3:0]  vid_pix, ser_data;
  logic [10:0] gfx_mx, gfx_my;
  logic [19:0] ser_addr;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  logic [11:0] r_off [8]  = '{CTRL_OFF, SCROLL_OFF, VSTART_OFF, VEND_OFF, GSTART_OFF, GEND_OFF, STATUS_OFF, LUT_OFF};
  logic [31:0] r_rst [8]  = '{32'h0, 32'h0, START_RST, VEND_RST, START_RST, GEND_RST, 32'h0, 32'h0};
  row_t        rows [11]  = '{
    '{2'h0, 1'h0, 4'h5, 4'h2, 4'h2}, '{2'h1, 1'h0, 4'h4, 4'ha, 4'h7}, '{2'h1, 1'h1, 4'h4, 4'ha, 4'h5},
    '{2'h1, 1'h0, 4'ha, 4'h3, 4'h6}, '{2'h1, 1'h1, 4'hf, 4'h0, 4'hb}, '{2'h2, 1'h0, 4'h4, 4'h9, 4'h9},
    '{2'h2, 1'h0, 4'h9, 4'h3, 4'h6}, '{2'h2, 1'h1, 4'h8, 4'h0, 4'h6}, '{2'h3, 1'h0, 4'h4, 4'h9, 4'h9},
    '{2'h3, 1'h0, 4'h9, 4'h3, 4'h9}, '{2'h3, 1'h1, 4'h7, 4'h7, 4'h7}};

  always #5 pclk = ~pclk;

  sensor_video_memory_processing dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .tv_valid, .tv_sample, .tv_x, .tv_y, .ser_valid, .ser_data, .ser_addr, .disp_req,
    .disp_x, .disp_y, .vid_valid, .vid_pix, .vid_blank, .gfx_req, .gfx_x, .gfx_y, .gfx_valid, .gfx_mx,
    .gfx_my, .gfx_blank);
  ser_source src_u (.pclk, .presetn, .go(s_go), .rush(s_rush), .pix(s_pix), .addr(s_addr), .busy(s_busy),
    .ser_valid, .ser_data, .ser_addr);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // idle cycle after each transfer keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic ser_put(input logic [19:0] a, input logic [3:0] d);
    s_addr <= a;
    s_pix  <= d;
    s_go   <= 1'b1;
    @(posedge pclk);
    s_go <= 1'b0;
    do @(negedge pclk); while (s_busy);
    @(posedge pclk);
  endtask

  task automatic tv_put(input logic [10:0] x, input logic [10:0] y, input logic [4:0] s);
    tv_x      <= x;
    tv_y      <= y;
    tv_sample <= s;
    tv_valid  <= 1'b1;
    @(posedge pclk);
    tv_valid  <= 1'b0;
    tv_sample <= ~s;
    @(posedge pclk);
  endtask

  task automatic disp_chk(input logic [9:0] x, input logic [9:0] y, input logic [3:0] e, input logic b);
    disp_x   <= x;
    disp_y   <= y;
    disp_req <= 1'b1;
    @(posedge pclk);
    disp_req <= 1'b0;
    @(negedge pclk);
    chk(32'({vid_valid, vid_blank, vid_pix}), 32'({1'b1, b, e}));
    @(posedge pclk);
  endtask

  task automatic gfx_chk(input logic [10:0] x, input logic [10:0] y, input logic [10:0] ex, input logic [10:0] ey);
    gfx_x   <= x;
    gfx_y   <= y;
    gfx_req <= 1'b1;
    @(posedge pclk);
    gfx_req <= 1'b0;
    @(negedge pclk);
    chk(32'({gfx_valid, gfx_blank, gfx_mx, gfx_my}), 32'({1'b1, 1'b0, ex, ey}));
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (r_off[i])
      rdc(r_off[i], r_rst[i]);  // reset state
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    foreach (rows[i])
    begin
      wr(CTRL_OFF, 32'h0);
      ser_put({10'(i), 10'(i + 1)}, rows[i].old);
      wr(CTRL_OFF, 32'({rows[i].k2, rows[i].mode}));
      ser_put({10'(i), 10'(i + 1)}, rows[i].nw);
      disp_chk(10'(i + 1), 10'(i), rows[i].exp, 1'b0);  // combine
    end
    wr(CTRL_OFF, 32'h0);
    ser_put({10'h014, 10'h014}, 4'h3);
    wr(CTRL_OFF, 32'h8);
    rdc(STATUS_OFF, 32'h2);  // freeze seen
    ser_put({10'h014, 10'h014}, 4'h9);
    disp_chk(10'h014, 10'h014, 4'h3, 1'b0);  // write blocked
    wr(CTRL_OFF, 32'h0);
    ser_put({10'h015, 10'h015}, 4'h6);
    wr(CTRL_OFF, 32'h10);
    disp_chk(10'h015, 10'h015, 4'h6, 1'b0);  // first read
    disp_chk(10'h015, 10'h015, 4'h0, 1'b0);  // cleared
    wr(CTRL_OFF, 32'h0);
    tv_put(11'h008, 11'h002, 5'h09);
    disp_chk(10'h008, 10'h002, 4'h4, 1'b0);  // linear table
    wr(LUT_OFF, 32'h0005_000c);
    rdc(LUT_OFF, 32'h0005_000c);  // table load
    tv_put(11'h009, 11'h002, 5'h05);
    disp_chk(10'h009, 10'h002, 4'hc, 1'b0);  // sliced
    ser_put({10'h003, 10'h008}, 4'h2);
    for (int f = 0; f < 4; f++)
    begin
      wr(CTRL_OFF, 32'(f << 7));
      tv_put(11'(16 + f), (f == 3) ? 11'h01f : 11'h006, 5'h1f);
      disp_chk(10'(16 + f), 10'h006, 4'hf, 1'b0);  // format and centring
    end
    tv_put(11'h008, 11'h003, 5'h09);
    disp_chk(10'h008, 10'h003, 4'h2, 1'b0);  // outside dropped
    wr(CTRL_OFF, 32'h0);
    ser_put({10'h004, 10'h003}, 4'hb);
    wr(CTRL_OFF, 32'h20);
    disp_chk(10'h006, 10'h008, 4'hb, 1'b0);  // times two
    wr(CTRL_OFF, 32'h40);
    disp_chk(10'h00c, 10'h010, 4'hb, 1'b0);  // times four
    wr(VSTART_OFF, 32'h0002_0001);
    disp_chk(10'h008, 10'h008, 4'hb, 1'b0);  // video window start
    wr(VSTART_OFF, START_RST);
    wr(VEND_OFF, 32'h03ff_0010);
    wr(CTRL_OFF, 32'h20);
    disp_chk(10'h030, 10'h008, 4'h0, 1'b1);  // past boundary
    wr(VEND_OFF, VEND_RST);
    wr(GSTART_OFF, 32'h0100_0100);
    gfx_chk(11'h110, 11'h120, 11'h108, 11'h110);  // inside window
    gfx_chk(11'h050, 11'h050, 11'h050, 11'h050);  // outside window
    wr(CTRL_OFF, 32'h0);
    ser_put({10'h005, 10'h01e}, 4'hd);
    wr(SCROLL_OFF, 32'h2);
    disp_chk(10'h01e, 10'h001, 4'hd, 1'b0);  // scrolled
    wr(SCROLL_OFF, 32'h0);
    s_rush <= 1'b1;
    ser_put({10'h030, 10'h030}, 4'h1);
    ser_put({10'h030, 10'h031}, 4'h1);
    s_rush <= 1'b0;
    rdc(STATUS_OFF, 32'h1);  // rate flagged
    wr(STATUS_OFF, 32'h1);
    rdc(STATUS_OFF, 32'h0);  // flag cleared
    close_out();
  end

  // ----------------------------------------------------------------
  // hang guard
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end
endmodule
